// ### hdl/dma_ctl_pkg.sv
// package: offsets, bit positions, reset values and types of the channel
package dma_ctl_pkg;
	// byte offsets inside one subchannel, and subchannel b base
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_MADDR  = 8'h04;
	localparam logic [7:0] OFS_IOADDR = 8'h08;
	localparam logic [7:0] OFS_COUNT  = 8'h0C;
	localparam logic [7:0] OFS_SUB_B  = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h0F;
	localparam logic [7:0] MAP_MASK   = 8'hE3;
	// channel control bit positions and subchannel select address bit
	localparam int EN_BIT   = 7;
	localparam int SIZE_BIT = 6;
	localparam int DIR_BIT  = 5;
	localparam int REP_BIT  = 4;
	localparam int IE_BIT   = 3;
	localparam int BLK_BIT  = 0;
	localparam int SUB_BIT  = 4;
	// activation source codes
	localparam logic [2:0] SEL_TX   = 3'h4;
	localparam logic [2:0] SEL_RX   = 3'h5;
	localparam logic [2:0] SEL_FALL = 3'h6;
	localparam logic [2:0] SEL_LOW  = 3'h7;
	localparam logic [1:0] SEL_FULL = 2'h3;
	localparam int NUM_SRC = 6;
	// values after reset and fixed fields
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  RSV_BYTE  = 8'hFF;
	localparam logic [15:0] IO_UPPER  = 16'hFFFF;
	localparam logic [23:0] STEP_BYTE = 24'h000001;
	localparam logic [23:0] STEP_WORD = 24'h000002;
	// operating modes of a short address subchannel
	typedef enum logic [2:0] {
		MODE_IO   = 3'b001,
		MODE_REP  = 3'b010,
		MODE_IDLE = 3'b100
	} mode_e;
	// transfer issue states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} issue_st_e;
	// one subchannel
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [23:0] addr;
		logic [7:0]  io;
		logic [15:0] cnt;
		logic        armed;
		logic        pend;
	} sub_s;
endpackage

// ### hdl/dma_channel_control_regs.sv
// two-subchannel transfer channel: registers, triggers and transfer issue

// Function
// R1 - control registers clear to zero on reset and standby entry
// R2 - enable bit set: wait for selected trigger, transfer; clear: ignore requests
// R3 - enable set needs a prior read showing it zero, then write one
// R4 - io and idle modes clear enable when count completes
// R5 - interrupt enable raises end interrupt when enable falls to zero, except on reset or standby entry
// R6 - size bit zero selects byte, one selects word transfers
// R7 - io and repeat modes step address by one or two, up or down
// R8 - idle mode never changes the memory address
// R9 - mode decoded from repeat bit and interrupt enable bit
// R10 - source codes pick timer, transmit empty or receive full triggers
// R11 - sub b codes 110, 111 use request pin edge or level
// R12 - shared trigger serves channels in fixed priority, highest first
// R13 - enabled channel blocks its trigger source from the cpu
// R14 - full mode: sub a address is source, sub b destination
// R15 - address top byte ignores writes and reads as all ones
// R16 - address and count registers are not reset
// R17 - fixed io addresses unused in full address mode
// R18 - full normal mode: sub a count decrements, ends at zero
// R19 - block mode: upper byte counts block, reloads from lower byte
// R20 - block mode: sub b counts blocks, transfer ends at zero
// R21 - full mode when both upper select bits of sub a set
// R22 - repeat mode: upper byte counts, reloads from lower byte at zero
// R23 - receive full trigger: memory is destination, io is source
// R24 - unarmed write of enable one leaves enable cleared
module dma_channel_control_regs (
	input  wire logic        core_clk_i,    // system clock
	input  wire logic        rstn_i,        // sync reset, low
	input  wire logic        standby_i,     // standby entry
	input  wire logic        psel_i,        // apb select
	input  wire logic        penable_i,     // apb enable
	input  wire logic        pwrite_i,      // apb direction
	input  wire logic [7:0]  paddr_i,       // apb byte address
	input  wire logic [31:0] pwdata_i,      // apb write data
	input  wire logic [3:0]  pstrb_i,       // apb byte strobes
	output logic      [31:0] prdata_o,      // apb read data
	output logic             pready_o,      // apb ready
	output logic             pslverr_o,     // apb error
	input  wire logic [5:0]  src_irq_i,     // trigger sources
	output logic      [5:0]  src_irq_o,     // sources to cpu
	input  wire logic        ext_req_n_i,   // request pin, low
	output logic             xfer_req_o,    // transfer request
	input  wire logic        xfer_ack_i,    // transfer done
	output logic             xfer_sub_o,    // 0 sub a, 1 sub b
	output logic      [31:0] xfer_src_o,    // source address
	output logic      [31:0] xfer_dst_o,    // destination
	output logic             xfer_word_o,   // word size
	output logic      [1:0]  end_irq_o      // end interrupt
);
	typedef struct packed {
		dma_ctl_pkg::sub_s [1:0] sub;
		dma_ctl_pkg::issue_st_e  st;
		logic                    sel;
		logic [31:0]             src;
		logic [31:0]             dst;
		logic                    word;
		logic [31:0]             rdata;
		logic [1:0]              end_irq;
		logic                    sync1;
		logic                    sync2;
		logic                    sync3;
	} state_s;

	state_s      r_reg;
	state_s      r_next;
	logic        full;
	logic [1:0]  act;
	logic [1:0]  hit;
	logic [2:0]  code_a;
	logic [2:0]  code_b;
	logic        fall;
	logic        low;
	logic [5:0]  claim;
	logic        mapped;
	logic        wr;
	logic        rd;
	logic        wsub;
	logic [7:0]  wofs;

	// mode of a short address subchannel
	function automatic dma_ctl_pkg::mode_e mode_of(input logic [7:0] c);
		// R9 mode decode
		if (!c[dma_ctl_pkg::REP_BIT])
			return dma_ctl_pkg::MODE_IO;
		else if (c[dma_ctl_pkg::IE_BIT])
			return dma_ctl_pkg::MODE_IDLE;
		else
			return dma_ctl_pkg::MODE_REP;
	endfunction

	// address step by one or two
	function automatic logic [23:0] step(input logic [23:0] a,
		input logic dec, input logic wd);
		logic [23:0] d;
		// R6 size select
		d = wd ? dma_ctl_pkg::STEP_WORD : dma_ctl_pkg::STEP_BYTE;
		// R7 step direction
		return dec ? a - d : a + d;
	endfunction

	// trigger decode for one source code
	function automatic logic fire(input logic [2:0] c, input logic isb,
		input logic [5:0] s, input logic f, input logic l);
		logic h;
		h = 1'b0;
		// R10 internal sources
		if (c < dma_ctl_pkg::SEL_FALL)
			h = s[c];
		// R11 request pin on sub b
		else if (isb)
			h = (c == dma_ctl_pkg::SEL_FALL) ? f : l;
		return h;
	endfunction

	// merge write data under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] w, input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				m[8*b +: 8] = w[8*b +: 8];
		return m;
	endfunction

	// register read value
	function automatic logic [31:0] rd_val(input dma_ctl_pkg::sub_s s,
		input logic [7:0] o);
		logic [31:0] v;
		v = 32'h0;
		case (o)
			dma_ctl_pkg::OFS_CTRL:   v = {24'h0, s.ctrl};
			// R15 reserved byte reads ones
			dma_ctl_pkg::OFS_MADDR:  v = {dma_ctl_pkg::RSV_BYTE, s.addr};
			dma_ctl_pkg::OFS_IOADDR: v = {24'h0, s.io};
			dma_ctl_pkg::OFS_COUNT:  v = {16'h0, s.cnt};
			default:                 v = 32'h0;
		endcase
		return v;
	endfunction

	// R21 full address decode
	assign full = r_reg.sub[0].ctrl[2:1] == dma_ctl_pkg::SEL_FULL;
	// R2 only enabled subchannels take requests
	assign act[0] = r_reg.sub[0].ctrl[dma_ctl_pkg::EN_BIT];
	assign act[1] = r_reg.sub[1].ctrl[dma_ctl_pkg::EN_BIT] & ~full;
	assign code_a = full ? r_reg.sub[1].ctrl[2:0] : r_reg.sub[0].ctrl[2:0];
	assign code_b = r_reg.sub[1].ctrl[2:0];
	// pin edge and level from synchronised copies only
	assign fall = r_reg.sync3 & ~r_reg.sync2;
	assign low  = ~r_reg.sync2;
	assign hit[0] = fire(code_a, full, src_irq_i, fall, low);
	assign hit[1] = fire(code_b, 1'b1, src_irq_i, fall, low);

	// sources claimed by an enabled subchannel
	for (genvar k = 0; k < dma_ctl_pkg::NUM_SRC; k++)
	begin : g_claim
		assign claim[k] = (act[0] & (code_a == 3'(k)))
			| (act[1] & (code_b == 3'(k)));
	end
	// R13 claimed sources hidden from cpu
	assign src_irq_o = src_irq_i & ~claim;

	// apb decode
	assign mapped = (paddr_i & dma_ctl_pkg::MAP_MASK) == 8'h00;
	assign wr     = psel_i & penable_i & pwrite_i & mapped;
	assign rd     = psel_i & penable_i & ~pwrite_i & mapped;
	assign wsub   = paddr_i[dma_ctl_pkg::SUB_BIT];
	assign wofs   = paddr_i & dma_ctl_pkg::OFS_MASK;

	// next state
	always_comb
	begin
		logic [31:0] m;
		logic [7:0]  v;
		logic [7:0]  up;
		logic        g;
		m = 32'h0;
		v = 8'h00;
		up = 8'h00;
		g = 1'b0;
		r_next = r_reg;
		r_next.end_irq = 2'b00;
		r_next.sync1 = ext_req_n_i;
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		// issue and completion
		case (r_reg.st)
			dma_ctl_pkg::ST_IDLE:
			begin
				// R12 sub a served before sub b
				g = ~(r_reg.sub[0].pend & act[0]);
				if ((r_reg.sub[0].pend & act[0]) | (r_reg.sub[1].pend & act[1]))
				begin
					r_next.st = dma_ctl_pkg::ST_BUSY;
					r_next.sel = g;
					r_next.sub[g].pend = 1'b0;
					r_next.word = full ? r_reg.sub[0].ctrl[dma_ctl_pkg::SIZE_BIT]
						: r_reg.sub[g].ctrl[dma_ctl_pkg::SIZE_BIT];
					if (full)
					begin
						// R14 a is source, b destination
						// R17 io addresses not used
						r_next.src = {dma_ctl_pkg::RSV_BYTE, r_reg.sub[0].addr};
						r_next.dst = {dma_ctl_pkg::RSV_BYTE, r_reg.sub[1].addr};
					end
					else if (r_reg.sub[g].ctrl[2:0] == dma_ctl_pkg::SEL_RX)
					begin
						// R23 receive full writes memory
						r_next.src = {dma_ctl_pkg::RSV_BYTE, dma_ctl_pkg::IO_UPPER,
							r_reg.sub[g].io};
						r_next.dst = {dma_ctl_pkg::RSV_BYTE, r_reg.sub[g].addr};
					end
					else
					begin
						r_next.src = {dma_ctl_pkg::RSV_BYTE, r_reg.sub[g].addr};
						r_next.dst = {dma_ctl_pkg::RSV_BYTE, dma_ctl_pkg::IO_UPPER,
							r_reg.sub[g].io};
					end
				end
			end
			dma_ctl_pkg::ST_BUSY:
			begin
				if (xfer_ack_i)
				begin
					r_next.st = dma_ctl_pkg::ST_IDLE;
					if (!r_reg.sel && full)
					begin
						r_next.sub[0].addr = step(r_reg.sub[0].addr,
							r_reg.sub[0].ctrl[dma_ctl_pkg::DIR_BIT],
							r_reg.sub[0].ctrl[dma_ctl_pkg::SIZE_BIT]);
						r_next.sub[1].addr = step(r_reg.sub[1].addr,
							r_reg.sub[1].ctrl[dma_ctl_pkg::DIR_BIT],
							r_reg.sub[0].ctrl[dma_ctl_pkg::SIZE_BIT]);
						if (!r_reg.sub[0].ctrl[dma_ctl_pkg::BLK_BIT])
						begin
							// R18 normal mode count
							r_next.sub[0].cnt = r_reg.sub[0].cnt - 16'h0001;
							if (r_next.sub[0].cnt == 16'h0000)
								r_next.sub[0].ctrl[dma_ctl_pkg::EN_BIT] = 1'b0;
						end
						else
						begin
							// R19 block size count and reload
							up = r_reg.sub[0].cnt[15:8] - 8'h01;
							r_next.sub[0].cnt[15:8] = up;
							if (up == 8'h00)
							begin
								r_next.sub[0].cnt[15:8] = r_reg.sub[0].cnt[7:0];
								// R20 block count ends transfer
								r_next.sub[1].cnt = r_reg.sub[1].cnt - 16'h0001;
								if (r_next.sub[1].cnt == 16'h0000)
									r_next.sub[0].ctrl[dma_ctl_pkg::EN_BIT] = 1'b0;
							end
						end
					end
					else
					begin
						case (mode_of(r_reg.sub[r_reg.sel].ctrl))
							dma_ctl_pkg::MODE_REP:
							begin
								r_next.sub[r_reg.sel].addr = step(
									r_reg.sub[r_reg.sel].addr,
									r_reg.sub[r_reg.sel].ctrl[dma_ctl_pkg::DIR_BIT],
									r_reg.sub[r_reg.sel].ctrl[dma_ctl_pkg::SIZE_BIT]);
								// R22 repeat count and reload
								up = r_reg.sub[r_reg.sel].cnt[15:8] - 8'h01;
								r_next.sub[r_reg.sel].cnt[15:8] = (up == 8'h00)
									? r_reg.sub[r_reg.sel].cnt[7:0] : up;
							end
							dma_ctl_pkg::MODE_IDLE:
							begin
								// R8 address held in idle mode
								r_next.sub[r_reg.sel].cnt =
									r_reg.sub[r_reg.sel].cnt - 16'h0001;
								// R4 end of count clears enable
								if (r_next.sub[r_reg.sel].cnt == 16'h0000)
									r_next.sub[r_reg.sel].ctrl[dma_ctl_pkg::EN_BIT] = 1'b0;
							end
							default:
							begin
								r_next.sub[r_reg.sel].addr = step(
									r_reg.sub[r_reg.sel].addr,
									r_reg.sub[r_reg.sel].ctrl[dma_ctl_pkg::DIR_BIT],
									r_reg.sub[r_reg.sel].ctrl[dma_ctl_pkg::SIZE_BIT]);
								// R4 end of count clears enable
								r_next.sub[r_reg.sel].cnt =
									r_reg.sub[r_reg.sel].cnt - 16'h0001;
								if (r_next.sub[r_reg.sel].cnt == 16'h0000)
									r_next.sub[r_reg.sel].ctrl[dma_ctl_pkg::EN_BIT] = 1'b0;
							end
						endcase
					end
				end
			end
			default: r_next.st = dma_ctl_pkg::ST_IDLE;
		endcase
		// requests: disabled ignores, new trigger wins over clear
		for (int i = 0; i < 2; i++)
		begin
			// R2 requests ignored while disabled
			if (!act[i])
				r_next.sub[i].pend = 1'b0;
			else if (hit[i])
				r_next.sub[i].pend = 1'b1;
		end
		// apb read data captured in setup phase
		if (psel_i && !penable_i)
			r_next.rdata = mapped ? rd_val(r_reg.sub[wsub], wofs) : 32'h0;
		// R3 read with enable clear arms the set
		if (rd && wofs == dma_ctl_pkg::OFS_CTRL
			&& !r_reg.sub[wsub].ctrl[dma_ctl_pkg::EN_BIT])
			r_next.sub[wsub].armed = 1'b1;
		// apb writes
		if (wr)
		begin
			case (wofs)
				dma_ctl_pkg::OFS_CTRL:
				begin
					if (pstrb_i[0])
					begin
						v = pwdata_i[7:0];
						// R24 unarmed set is dropped
						v[dma_ctl_pkg::EN_BIT] = pwdata_i[dma_ctl_pkg::EN_BIT]
							& (r_reg.sub[wsub].ctrl[dma_ctl_pkg::EN_BIT]
							| r_reg.sub[wsub].armed);
						r_next.sub[wsub].ctrl = v;
						r_next.sub[wsub].armed = 1'b0;
					end
				end
				dma_ctl_pkg::OFS_MADDR:
				begin
					// R15 top byte write ignored
					m = merge({8'h00, r_reg.sub[wsub].addr}, pwdata_i, pstrb_i);
					r_next.sub[wsub].addr = m[23:0];
				end
				dma_ctl_pkg::OFS_IOADDR:
				begin
					if (pstrb_i[0])
						r_next.sub[wsub].io = pwdata_i[7:0];
				end
				dma_ctl_pkg::OFS_COUNT:
				begin
					m = merge({16'h0000, r_reg.sub[wsub].cnt}, pwdata_i, pstrb_i);
					r_next.sub[wsub].cnt = m[15:0];
				end
				default: r_next.sub[wsub].io = r_reg.sub[wsub].io;
			endcase
		end
		// R5 end interrupt on enable falling
		for (int i = 0; i < 2; i++)
			r_next.end_irq[i] = r_reg.sub[i].ctrl[dma_ctl_pkg::EN_BIT]
				& ~r_next.sub[i].ctrl[dma_ctl_pkg::EN_BIT]
				& r_reg.sub[i].ctrl[dma_ctl_pkg::IE_BIT] & ~standby_i;
		// R1 reset and standby clear control
		// R16 address and count keep contents
		if (!rstn_i || standby_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				r_next.sub[i].ctrl = dma_ctl_pkg::CTRL_RST;
				r_next.sub[i].armed = 1'b0;
				r_next.sub[i].pend = 1'b0;
			end
		end
		if (!rstn_i)
		begin
			r_next.st = dma_ctl_pkg::ST_IDLE;
			r_next.sel = 1'b0;
			r_next.src = 32'h0;
			r_next.dst = 32'h0;
			r_next.word = 1'b0;
			r_next.rdata = 32'h0;
			r_next.end_irq = 2'b00;
			r_next.sync1 = 1'b1;
			r_next.sync2 = 1'b1;
			r_next.sync3 = 1'b1;
		end
	end

	// state register
	always_ff @(posedge core_clk_i)
		r_reg <= r_next;

	// outputs
	assign prdata_o    = r_reg.rdata;
	assign pready_o    = 1'b1;
	assign pslverr_o   = psel_i & penable_i & ~mapped;
	assign xfer_req_o  = r_reg.st == dma_ctl_pkg::ST_BUSY;
	assign xfer_sub_o  = r_reg.sel;
	assign xfer_src_o  = r_reg.src;
	assign xfer_dst_o  = r_reg.dst;
	assign xfer_word_o = r_reg.word;
	assign end_irq_o   = r_reg.end_irq;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_done_a;
		xfer_req_o && !r_reg.sel && !full && xfer_ack_i && !wr;
	endsequence
	sequence s_set_unarmed;
		wr && wofs == dma_ctl_pkg::OFS_CTRL && pstrb_i[0] && pwdata_i[7]
			&& !r_reg.sub[wsub].armed && !r_reg.sub[wsub].ctrl[7];
	endsequence

	AST_RESET_CLEAR: assert property (disable iff (1'b0) // R1
		!rstn_i |=> r_reg.sub[0].ctrl == 8'h00 && r_reg.sub[1].ctrl == 8'h00)
		else $error("control not cleared by reset");
	AST_OFF_NO_PEND: assert property ( // R2
		!act[0] |=> !r_reg.sub[0].pend)
		else $error("request kept while disabled");
	AST_UNARMED_SET: assert property ( // R24
		s_set_unarmed and !wsub |=> !r_reg.sub[0].ctrl[7])
		else $error("enable set without read");
	AST_END_IRQ: assert property ( // R5
		$fell(r_reg.sub[0].ctrl[7]) && $past(r_reg.sub[0].ctrl[3])
		&& $past(rstn_i) && !$past(standby_i) |-> end_irq_o[0])
		else $error("end interrupt missing");
	AST_IDLE_HOLD: assert property ( // R8
		s_done_a ##0 mode_of(r_reg.sub[0].ctrl) == dma_ctl_pkg::MODE_IDLE
		|=> $stable(r_reg.sub[0].addr))
		else $error("address moved in idle mode");
	AST_STEP_WORD: assert property ( // R7
		s_done_a ##0 r_reg.sub[0].ctrl[6:4] == 3'b100
		|=> r_reg.sub[0].addr == $past(r_reg.sub[0].addr) + 24'h2)
		else $error("word increment wrong");
	AST_PRIO: assert property ( // R12
		r_reg.st == dma_ctl_pkg::ST_IDLE && r_reg.sub[0].pend && act[0]
		|=> xfer_req_o && !xfer_sub_o)
		else $error("priority not kept");
	AST_CLAIM: assert property ( // R13
		act[0] && !full && code_a == 3'h4 |-> !src_irq_o[4])
		else $error("claimed source reached cpu");
	AST_RSV_READ: assert property ( // R15
		psel_i && !penable_i && !pwrite_i
		&& paddr_i == dma_ctl_pkg::OFS_MADDR
		|=> prdata_o[31:24] == 8'hFF)
		else $error("reserved byte not ones");
	AST_IO_END: assert property ( // R4
		s_done_a ##0 !r_reg.sub[0].ctrl[4] && r_reg.sub[0].cnt == 16'h1
		|=> !r_reg.sub[0].ctrl[7]
		&& end_irq_o[0] == $past(r_reg.sub[0].ctrl[3]))
		else $error("enable not cleared at end of count");
endmodule

// ### tb/mem_partner.sv
// memory side of the transfer port: acknowledges each request after a delay
module mem_partner (
	input  wire logic       clk_i,  // system clock
	input  wire logic       rstn_i, // sync reset, low
	input  wire logic       req_i,  // transfer request
	input  wire logic [1:0] dly_i,  // wait cycles before ack
	output logic            ack_o   // one-cycle transfer done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_reg;
	// count wait cycles, one ack per request level
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			wait_reg <= 2'h0;
			ack_o    <= 1'b0;
		end
		else
		begin
			ack_o <= 1'b0;
			if (req_i && !ack_o)
			begin
				if (wait_reg >= dly_i)
				begin
					ack_o    <= 1'b1;
					wait_reg <= 2'h0;
				end
				else
					wait_reg <= wait_reg + 2'h1;
			end
		end
	end
endmodule

// ### tb/tb.sv
// bench for the channel registers, triggers and transfer issue
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MA = dma_ctl_pkg::OFS_MADDR;
	localparam logic [7:0] IOA = dma_ctl_pkg::OFS_IOADDR;
	localparam logic [7:0] CN = dma_ctl_pkg::OFS_COUNT;
	localparam logic [7:0] SB = dma_ctl_pkg::OFS_SUB_B;
	logic        clk, rstn, stby, psel, pen, pwr, perr, pready, pslverr;
	logic        ext_n, req, ack, sub, word;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, src, dst;
	logic [3:0]  pstrb;
	logic [5:0]  irq_in, irq_out;
	logic [1:0]  endi, dly;
	int          n_errors, tests_run, cyc, seed, j, n;
	int          ends [2] = '{0, 0};
	logic        s;
	logic [2:0]  sel;
	logic [3:0]  m;
	logic [15:0] c;

	dma_channel_control_regs u_dut (.core_clk_i(clk), .rstn_i(rstn),
		.standby_i(stby), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.src_irq_i(irq_in), .src_irq_o(irq_out), .ext_req_n_i(ext_n),
		.xfer_req_o(req), .xfer_ack_i(ack), .xfer_sub_o(sub),
		.xfer_src_o(src), .xfer_dst_o(dst), .xfer_word_o(word),
		.end_irq_o(endi));
	mem_partner u_mem (.clk_i(clk), .rstn_i(rstn), .req_i(req),
		.dly_i(dly), .ack_o(ack));

	// free running clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// count end pulses, cut a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (endi[0] === 1'b1) ends[0]++;
		if (endi[1] === 1'b1) ends[1]++;
		if (cyc == 20000)
		begin
			n_errors++;
			summarize;
		end
	end

	task summarize;
		$display("tests %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; read data and error taken at the completing edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd   = prdata;
		perr = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task enable(input logic [7:0] b, input logic [7:0] v);
		apb(1'b0, b, 32'h0);
		wr(b, {24'h0, v});
	endtask

	// pulse a source, or pull the request pin low for a while
	task trig(input logic sb, input logic [2:0] k, input logic claim);
		@(posedge clk);
		if (sb && k[2:1] == 2'b11)
		begin
			ext_n <= 1'b0;
			// edge code holds low, level code one cycle only
			repeat (k[0] ? 1 : 4) @(posedge clk);
			ext_n <= 1'b1;
		end
		else
		begin
			irq_in[k] <= 1'b1;
			@(posedge clk);
			check(irq_out[k], !claim);
			irq_in[k] <= 1'b0;
		end
	endtask

	task wait_req;
		int i;
		for (i = 0; i < 40 && req !== 1'b1; i++) @(posedge clk);
		check(req, 1'b1);
	endtask

	task fin;
		while (req === 1'b1) @(posedge clk);
	endtask

	function logic [23:0] step(input logic [23:0] a, input logic d, w);
		logic [23:0] st;
		st = w ? dma_ctl_pkg::STEP_WORD : dma_ctl_pkg::STEP_BYTE;
		return d ? a - st : a + st;
	endfunction

	// short address run; md holds size, direction, repeat, irq enable
	task run_short(input logic sb, input logic [2:0] k, input logic [3:0] md,
		input logic [15:0] cnt, input int nx);
		logic [7:0]  b, ctl, io, hi;
		logic [23:0] a;
		int          i, e0;
		logic        en;
		b = sb ? SB : 8'h00;
		a = 24'($random(seed));
		io = 8'($random(seed));
		ctl = {1'b1, md, k};
		e0 = ends[sb];
		en = 1'b1;
		wr(b | MA, {8'h00, a});
		wr(b | IOA, {24'h0, io});
		wr(b | CN, {16'h0, cnt});
		enable(b, ctl);
		for (i = 0; i < nx; i++)
		begin
			trig(sb, k, 1'b1);
			wait_req;
			check(sub, sb);
			check(word, md[3]);
			check(k == dma_ctl_pkg::SEL_RX ? src : dst, {24'hFFFFFF, io});
			check(k == dma_ctl_pkg::SEL_RX ? dst : src, {8'hFF, a});
			fin;
			if (!(md[1] && md[0])) a = step(a, md[2], md[3]);
			// repeat reload or count to end
			if (md[1] && !md[0])
			begin
				hi = cnt[15:8] - 8'h01;
				cnt = hi == 8'h00 ? {cnt[7:0], cnt[7:0]} : {hi, cnt[7:0]};
			end
			else
			begin
				cnt = cnt - 16'h1;
				en = cnt != 16'h0;
			end
		end
		rdc(b | MA, {8'hFF, a});
		rdc(b | CN, {16'h0, cnt});
		rdc(b, {24'h0, en, ctl[6:0]});
		check(ends[sb] - e0, (md[0] && !en) ? 1 : 0);
		wr(b, 32'h0);
		$display("test short sub %0d sel %0d mode %h done", sb, k, md);
	endtask

	initial
	begin
		seed = 32'h538BAA26;
		{rstn, stby, psel, pen, pwr, paddr, pwdata} = '0;
		{irq_in, dly, perr, rd} = '0;
		pstrb = 4'hF;
		ext_n = 1'b1;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rdc(SB, 32'h0);
		wr(8'h00, 32'h80);
		rdc(8'h00, 32'h0);
		wr(8'h00, 32'h80);
		rdc(8'h00, 32'h80);
		wr(8'h00, 32'h0);
		wr(MA, 32'h12345678);
		rdc(MA, 32'hFF345678);
		apb(1'b0, 8'h22, 32'h0);
		check(perr, 1'b1);
		check(rd, 32'h0);
		$display("test registers done");
		run_short(1'b1, 3'h6, 4'hA, 16'h0203, 3);
		run_short(1'b0, 3'h5, 4'h3, 16'h0002, 2);
		run_short(1'b0, 3'h2, 4'hE, 16'h0102, 3);
		run_short(1'b1, 3'h4, 4'h9, 16'h0003, 3);
		run_short(1'b0, 3'h3, 4'h9, 16'h0002, 2);
		run_short(1'b1, 3'h7, 4'h0, 16'h0002, 2);
		for (j = 0; j < 8; j++)
		begin
			s = j[0];
			sel = 3'({$random(seed)} % (s ? 8 : 6));
			m = 4'($random(seed));
			dly = 2'($random(seed));
			c = 16'(1 + {$random(seed)} % 3);
			n = c;
			if (m[1] && !m[0])
			begin
				c = {8'(1 + {$random(seed)} % 2), c[7:0]};
				n = 3;
			end
			run_short(s, sel, m, c, n);
		end
		// both subchannels share one timer source
		wr(CN, 32'h1);
		wr(SB | CN, 32'h1);
		enable(8'h00, 8'h81);
		enable(SB, 8'h81);
		trig(1'b0, 3'h1, 1'b1);
		wait_req;
		check(sub, 1'b0);
		fin;
		wait_req;
		check(sub, 1'b1);
		fin;
		trig(1'b0, 3'h1, 1'b0);
		repeat (12) @(posedge clk);
		check(req, 1'b0);
		$display("test priority done");
		// full address, normal then block counting
		wr(SB, 32'h0);
		wr(MA, 32'h00ABCDEF);
		wr(SB | MA, 32'h00123456);
		wr(CN, 32'h2);
		enable(8'h00, 8'h86);
		trig(1'b0, 3'h0, 1'b1);
		wait_req;
		check(src, 32'hFFABCDEF);
		check(dst, 32'hFF123456);
		fin;
		rdc(CN, 32'h1);
		trig(1'b0, 3'h0, 1'b1);
		wait_req;
		fin;
		rdc(8'h00, 32'h06);
		wr(CN, 32'h0101);
		wr(SB | CN, 32'h2);
		enable(8'h00, 8'h87);
		trig(1'b0, 3'h0, 1'b1);
		wait_req;
		fin;
		rdc(CN, 32'h0101);
		rdc(SB | CN, 32'h1);
		trig(1'b0, 3'h0, 1'b1);
		wait_req;
		fin;
		rdc(SB | CN, 32'h0);
		rdc(8'h00, 32'h07);
		$display("test full mode done");
		// standby and reset clear control only
		wr(8'h00, 32'h15);
		wr(SB, 32'h15);
		@(posedge clk);
		stby <= 1'b1;
		@(posedge clk);
		stby <= 1'b0;
		rdc(8'h00, 32'h0);
		rdc(MA, 32'hFFABCDF3);
		wr(SB, 32'h15);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc(SB, 32'h0);
		rdc(SB | CN, 32'h0);
		rdc(SB | MA, 32'hFF12345A);
		$display("test standby reset done");
		summarize;
	end
endmodule
